/* design/diff_clock_output_gating.sv */
`timescale 1ns/1ps
`include "diff_clock_output_gating_cfg.svh"
module diff_clock_output_gating
  import diff_clock_output_gating_pkg::*;
#(
  parameter int LOCK_CYC = `LOCK_NS / `CLK_NS - `LOCK_MARGIN,
  parameter logic [3:0] REV_CODE = 4'h3,    // Arbitrary value
  parameter logic [3:0] MAKER_CODE = 4'h5,  // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'h5a   // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic comp_clk_i,
  input wire logic power_down_n_i,
  input wire logic output_halt_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [7:0] out_run_o,
  output logic [7:0] out_true_oe_o,
  output logic [7:0] out_comp_oe_o,
  output logic pll_run_o,
  output logic loop_bandwidth_select_o,
  output logic zero_delay_mode_o,
  output logic input_halving_select_o
);
  // ****************************************
  // Reset release
  // ****************************************
  logic rs1_reg, rst_n, lrs1_reg, lrst_n;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rs1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_reg <= 1'b1;
      rst_n <= rs1_reg;
    end
  end

  always_ff @(posedge comp_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lrs1_reg <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrs1_reg <= 1'b1;
      lrst_n <= lrs1_reg;
    end
  end

  // ****************************************
  // Serial slave and register bank
  // ****************************************
  core_s c_reg, c_next;
  link_s l_reg, l_next;
  park_s p_reg, p_next;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic [7:0] rd_data;

  function automatic logic [7:0] rd_byte(input core_s c);
    case (c.idx)
      `OFS_MODE: rd_byte = c.mode;
      `OFS_EN: rd_byte = c.en;
      `OFS_STP: rd_byte = c.stp;
      `OFS_SPARE: rd_byte = c.spare;
      `OFS_ID: rd_byte = {REV_CODE, MAKER_CODE};
      `OFS_PART: rd_byte = PART_CODE;
      `OFS_LEN: rd_byte = c.len;
      default: rd_byte = 8'h00;
    endcase
  endfunction

  assign scl_rise = c_reg.scl_s2 && !c_reg.scl_q;
  assign scl_fall = !c_reg.scl_s2 && c_reg.scl_q;
  assign start_c = c_reg.scl_s2 && c_reg.scl_q && !c_reg.sda_s2 && c_reg.sda_q;
  assign stop_c = c_reg.scl_s2 && c_reg.scl_q && c_reg.sda_s2 && !c_reg.sda_q;
  // Named net, a bit select on a call result is not portable
  assign rd_data = rd_byte(c_reg);

  always_comb begin
    c_next = c_reg;
    c_next.scl_s1 = scl_i;
    c_next.scl_s2 = c_reg.scl_s1;
    c_next.scl_q = c_reg.scl_s2;
    c_next.sda_s1 = sda_i;
    c_next.sda_s2 = c_reg.sda_s1;
    c_next.sda_q = c_reg.sda_s2;
    if (start_c) begin
      c_next.st = ST_RX;
      c_next.bits = 4'h0;
      c_next.nbyte = 2'd0;
      c_next.sda_oe = 1'b0;
    end else if (stop_c) begin
      c_next.st = ST_IDLE;
      c_next.sda_oe = 1'b0;
    end else if (scl_rise) begin
      if (c_reg.st == ST_RX) begin
        c_next.sh = {c_reg.sh[6:0], c_reg.sda_s2};
        c_next.bits = c_reg.bits + 4'h1;
      end else if (c_reg.st == ST_RACK) begin
        c_next.nack = c_reg.sda_s2;
      end
    end else if (scl_fall) begin
      case (c_reg.st)
        ST_RX: begin
          if (c_reg.bits == `BYTE_BITS) begin
            c_next.st = ST_ACK;
            c_next.sda_oe = 1'b1;
            if (c_next.nbyte != 2'd3) begin
              c_next.nbyte = c_reg.nbyte + 2'd1;
            end
            case (c_reg.nbyte)
              2'd0: begin
                c_next.rw = (c_reg.sh == `ADDR_RD);
                if (c_reg.sh != `ADDR_WR && c_reg.sh != `ADDR_RD) begin
                  c_next.st = ST_IDLE;
                  c_next.sda_oe = 1'b0;
                end
              end
              2'd1: c_next.idx = c_reg.sh;
              2'd2: c_next.cnt = c_reg.sh;
              default: begin
                if (c_reg.cnt != 8'h00) begin
                  c_next.cnt = c_reg.cnt - 8'h01;
                  c_next.idx = c_reg.idx + 8'h01;
                  case (c_reg.idx)
                    `OFS_MODE: c_next.mode = c_reg.sh;
                    `OFS_EN: c_next.en = c_reg.sh;
                    `OFS_STP: c_next.stp = c_reg.sh;
                    `OFS_SPARE: c_next.spare = c_reg.sh;
                    `OFS_LEN: c_next.len = c_reg.sh;
                    default: c_next.cnt = c_reg.cnt - 8'h01;
                  endcase
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          c_next.bits = 4'h0;
          c_next.sda_oe = 1'b0;
          c_next.st = ST_RX;
          if (c_reg.rw) begin
            // Block read opens with the length byte
            c_next.st = ST_TX;
            c_next.sh = c_reg.len;
            c_next.sda_oe = !c_reg.len[7];
            c_next.bits = 4'h1;
          end
        end
        ST_TX: begin
          if (c_reg.bits == `BYTE_BITS) begin
            c_next.st = ST_RACK;
            c_next.sda_oe = 1'b0;
          end else begin
            c_next.sh = {c_reg.sh[6:0], 1'b0};
            c_next.sda_oe = !c_reg.sh[6];
            c_next.bits = c_reg.bits + 4'h1;
          end
        end
        ST_RACK: begin
          if (c_reg.nack) begin
            c_next.st = ST_IDLE;
          end else begin
            c_next.st = ST_TX;
            c_next.sh = rd_data;
            c_next.sda_oe = !rd_data[7];
            c_next.idx = c_reg.idx + 8'h01;
            c_next.bits = 4'h1;
          end
        end
        default: c_next.st = ST_IDLE;
      endcase
    end
    // PLL relock timer, restarted whenever the PLL is halted
    c_next.pr_s1 = l_reg.pll_run;
    c_next.pr_s2 = c_reg.pr_s1;
    if (!c_reg.pr_s2) begin
      c_next.lock_cnt = '0;
      c_next.lock_done = 1'b0;
    end else if (c_reg.lock_cnt == LOCK_CYC[`LOCK_W-1:0] - 1'b1) begin
      c_next.lock_done = 1'b1;
    end else begin
      c_next.lock_cnt = c_reg.lock_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      c_reg <= '0;
      c_reg.st <= ST_IDLE;
      c_reg.scl_s1 <= 1'b1;
      c_reg.scl_s2 <= 1'b1;
      c_reg.scl_q <= 1'b1;
      c_reg.sda_s1 <= 1'b1;
      c_reg.sda_s2 <= 1'b1;
      c_reg.sda_q <= 1'b1;
      c_reg.mode <= `RST_MODE;
      c_reg.en <= `RST_EN;
      c_reg.stp <= `RST_STP;
      c_reg.spare <= `RST_SPARE;
      c_reg.len <= `RST_LEN;
    end else begin
      c_reg <= c_next;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = c_reg.sda_oe;
  assign loop_bandwidth_select_o = c_reg.mode[`B_BW];
  assign zero_delay_mode_o = c_reg.mode[`B_ZDB];
  assign input_halving_select_o = c_reg.mode[`B_DIV];

  // ****************************************
  // Link side qualification
  // ****************************************
  always_comb begin
    l_next = l_reg;
    l_next.pd_s1 = power_down_n_i;
    l_next.pd_s2 = l_reg.pd_s1;
    l_next.pd_prev = l_reg.pd_s2;
    l_next.pd_req = !l_reg.pd_s2 && !l_reg.pd_prev;
    l_next.hl_s1 = output_halt_n_i;
    l_next.hl_s2 = l_reg.hl_s1;
    l_next.hl_prev = l_reg.hl_s2;
    if (l_reg.hl_s2 == l_reg.hl_prev) begin
      l_next.halt_q = !l_reg.hl_s2;
    end
    if (l_reg.halt_q) begin
      l_next.stop_act = 1'b1;
      l_next.rcnt = 2'd0;
    end else if (l_reg.stop_act) begin
      l_next.rcnt = l_reg.rcnt + 2'd1;
      if (l_reg.rcnt == `RESUME_CYC - 2'd1) begin
        l_next.stop_act = 1'b0;
      end
    end
    // Halt the PLL only once the outputs are parked
    l_next.pll_run = !(l_reg.pd_req && p_reg.pd_park);
    // Quasi-static settings, each bit synchronised on its own
    l_next.cfg_s1 = {c_reg.mode[`B_SLEEP], c_reg.mode[`B_STOP], c_reg.en, c_reg.stp};
    l_next.cfg_s2 = l_reg.cfg_s1;
    l_next.lk_s1 = c_reg.lock_done;
    l_next.lk_s2 = l_reg.lk_s1;
  end

  always_ff @(posedge comp_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      l_reg <= '0;
      l_reg.pd_s1 <= 1'b1;
      l_reg.pd_s2 <= 1'b1;
      l_reg.pd_prev <= 1'b1;
      l_reg.hl_s1 <= 1'b1;
      l_reg.hl_s2 <= 1'b1;
      l_reg.hl_prev <= 1'b1;
    end else begin
      l_reg <= l_next;
    end
  end

  // ****************************************
  // Output parking on falling edges
  // ****************************************
  always_comb begin
    p_next = '0;
    p_next.pd_park = l_reg.pd_req || !l_reg.lk_s2;
    for (int i = 0; i < 8; i++) begin
      if (p_next.pd_park) begin
        // Mode 1 wakes driven high while the PLL relocks
        p_next.toe[i] = l_reg.cfg_s2[8 + i] && (!l_reg.cfg_s2[17] || !l_reg.pd_req);
      end else if (!l_reg.cfg_s2[8 + i]) begin
        p_next.toe[i] = 1'b0;
      end else if (l_reg.stop_act && l_reg.cfg_s2[i]) begin
        p_next.toe[i] = !l_reg.cfg_s2[16] || !l_reg.halt_q;
      end else begin
        p_next.run[i] = 1'b1;
        p_next.toe[i] = 1'b1;
        p_next.coe[i] = 1'b1;
      end
    end
  end

  always_ff @(negedge comp_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      p_reg <= '0;
      p_reg.pd_park <= 1'b1;
    end else begin
      p_reg <= p_next;
    end
  end

  assign out_run_o = p_reg.run;
  assign out_true_oe_o = p_reg.toe;
  assign out_comp_oe_o = p_reg.coe;
  assign pll_run_o = l_reg.pll_run;

  // ****************************************
  // Checks
  // ****************************************
  chk_pd_qualify: assert property (@(posedge comp_clk_i) disable iff (!lrst_n)
    (!l_reg.pd_s2 [*2]) |=> l_reg.pd_req) else $error("power-down not qualified");
  chk_pd_park: assert property (@(posedge comp_clk_i) disable iff (!lrst_n)
    l_reg.pd_req |=> (out_run_o == 8'h00)) else $error("outputs not parked");
  chk_pll_after: assert property (@(posedge comp_clk_i) disable iff (!lrst_n)
    $fell(l_reg.pll_run) |-> (out_run_o == 8'h00)) else $error("PLL halted early");
  chk_sleep_drive: assert property (@(posedge comp_clk_i) disable iff (!lrst_n)
    (l_reg.pd_req && p_reg.pd_park && !l_reg.cfg_s2[17]) |->
      (out_comp_oe_o == 8'h00 && out_true_oe_o == l_reg.cfg_s2[15:8]))
    else $error("sleep drive mode 0 wrong");
  chk_sleep_hiz: assert property (@(posedge comp_clk_i) disable iff (!lrst_n)
    (l_reg.pd_req && p_reg.pd_park && l_reg.cfg_s2[17]) |->
      ((out_true_oe_o | out_comp_oe_o) == 8'h00)) else $error("sleep drive mode 1 wrong");
  chk_free_run: assert property (@(posedge comp_clk_i) disable iff (!lrst_n)
    (!p_reg.pd_park && $stable(l_reg.cfg_s2)) |->
      ((out_run_o & ~l_reg.cfg_s2[7:0]) == (l_reg.cfg_s2[15:8] & ~l_reg.cfg_s2[7:0])))
    else $error("free-running pair stopped");
  chk_resume_lat: assert property (@(posedge comp_clk_i) disable iff (!lrst_n)
    $fell(l_reg.halt_q) |-> ##[2:6] !l_reg.stop_act) else $error("resume too late");
  chk_stop_release: assert property (@(posedge comp_clk_i) disable iff (!lrst_n)
    ($fell(l_reg.halt_q) && !l_reg.pd_req && l_reg.lk_s2) |=>
      ((out_true_oe_o & l_reg.cfg_s2[15:8]) == l_reg.cfg_s2[15:8]))
    else $error("stopped outputs not driven on release");
  chk_addr_ack: assert property (@(posedge clk_i) disable iff (!rst_n)
    (scl_fall && c_reg.st == ST_RX && c_reg.bits == `BYTE_BITS && c_reg.nbyte == 2'd0 &&
      (c_reg.sh == `ADDR_WR || c_reg.sh == `ADDR_RD)) |=> (sda_oe_o && c_reg.st == ST_ACK))
    else $error("address not acknowledged");

  // ****************************************
  // Further checks
  // ****************************************
  chk_halt_debounce: assert property (@(posedge comp_clk_i) disable iff (!lrst_n)
    (l_reg.hl_s2 != l_reg.hl_prev) |=> $stable(l_reg.halt_q)) else $error("halt not debounced");
  chk_stop_hold: assert property (@(posedge comp_clk_i) disable iff (!lrst_n)
    (!p_reg.pd_park && l_reg.stop_act) |->
      ((out_run_o & l_reg.cfg_s2[7:0]) == 8'h00)) else $error("stoppable pair still running");
  chk_disabled_off: assert property (@(posedge comp_clk_i) disable iff (!lrst_n)
    ((~l_reg.cfg_s2[15:8] & (out_run_o | out_true_oe_o | out_comp_oe_o)) == 8'h00))
    else $error("disabled pair driven");
  chk_read_nack: assert property (@(posedge clk_i) disable iff (!rst_n)
    (scl_fall && c_reg.st == ST_RACK && c_reg.nack) |=> (c_reg.st == ST_IDLE && !sda_oe_o))
    else $error("read not ended on not-acknowledge");
  chk_lock_restart: assert property (@(posedge clk_i) disable iff (!rst_n)
    !c_reg.pr_s2 |=> !c_reg.lock_done) else $error("lock timer not restarted");
endmodule

/* design/diff_clock_output_gating_cfg.svh */
`ifndef DIFF_CLOCK_OUTPUT_GATING_CFG_SVH
`define DIFF_CLOCK_OUTPUT_GATING_CFG_SVH
`define ADDR_WR 8'hdc
`define ADDR_RD 8'hdd
`define OFS_MODE 8'h00
`define OFS_EN 8'h01
`define OFS_STP 8'h02
`define OFS_SPARE 8'h03
`define OFS_ID 8'h04
`define OFS_PART 8'h05
`define OFS_LEN 8'h06
`define B_SLEEP 7
`define B_STOP 6
`define B_BW 2
`define B_ZDB 1
`define B_DIV 0
`define RST_MODE 8'h07
`define RST_EN 8'hff
`define RST_STP 8'h00
`define RST_SPARE 8'h00
`define RST_LEN 8'h07
`define BYTE_BITS 4'h8
`define CLK_NS 10
`define LOCK_NS 1000000
`define LOCK_MARGIN 64
`define RESUME_CYC 2'd2
`define LOCK_W 24
`endif

/* design/diff_clock_output_gating_pkg.sv */
`include "diff_clock_output_gating_cfg.svh"
package diff_clock_output_gating_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_RACK = 5'h10
  } smb_state_e;

  typedef struct packed {
    logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
    smb_state_e st;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [1:0] nbyte;
    logic rw, nack, sda_oe;
    logic [7:0] idx, cnt, mode, en, stp, spare, len;
    logic pr_s1, pr_s2, lock_done;
    logic [`LOCK_W-1:0] lock_cnt;
  } core_s;

  typedef struct packed {
    logic pd_s1, pd_s2, pd_prev, pd_req;
    logic hl_s1, hl_s2, hl_prev, halt_q, stop_act;
    logic [1:0] rcnt;
    logic [17:0] cfg_s1, cfg_s2;
    logic lk_s1, lk_s2, pll_run;
  } link_s;

  typedef struct packed {
    logic [7:0] run, toe, coe;
    logic pd_park;
  } park_s;
endpackage

/* test/diff_clock_output_gating_test.sv */
`timescale 1ns/1ps
`include "diff_clock_output_gating_cfg.svh"
module diff_clock_output_gating_test;
  localparam int LOCK = 20;
  localparam logic [3:0] REV = 4'h9;    // Arbitrary value
  localparam logic [3:0] MAKER = 4'h6;  // Arbitrary value
  localparam logic [7:0] PART = 8'hc3;  // Arbitrary value
  logic clk_i, comp_clk_i, reset_n_i, power_down_n_i, output_halt_n_i;
  logic scl, sda, sda_o, sda_oe, pll_run, bw, zero_delay_mode, div;
  logic [7:0] out_run, toe, coe, msk, en, m;
  logic [7:0] regs [0:7];
  int errors, total_checks, k;
  diff_clock_output_gating #(.LOCK_CYC(LOCK), .REV_CODE(REV), .MAKER_CODE(MAKER),
    .PART_CODE(PART)) diff_clock_output_gating_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .comp_clk_i(comp_clk_i),
    .power_down_n_i(power_down_n_i), .output_halt_n_i(output_halt_n_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .out_run_o(out_run), .out_true_oe_o(toe), .out_comp_oe_o(coe),
    .pll_run_o(pll_run), .loop_bandwidth_select_o(bw), .zero_delay_mode_o(zero_delay_mode),
    .input_halving_select_o(div));
  smbus_host_model host_i (.clk_i(clk_i), .dev_pull_i(sda_oe & ~sda_o), .scl_o(scl),
    .sda_o(sda));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Reference keeps running for the whole run
  initial begin
    comp_clk_i = 1'b0;
    #2;
    forever #7.5 comp_clk_i = ~comp_clk_i;
  end
  // ************************************
  // Checking helpers
  // ************************************
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic logic [7:0] exp_rd(input int j);
    if (j == 4) return {REV, MAKER};
    if (j == 5) return PART;
    return (j <= 6) ? regs[j] : 8'h00;
  endfunction
  task automatic chk_out(input logic [7:0] r, input logic [7:0] t, input logic [7:0] c);
    #1;
    cmp(out_run, r);
    cmp(toe, t);
    cmp(coe, c);
  endtask
  // Counts falling edges until a pin group matches; window lo..hi
  task automatic wait_eq(input bit sel, input logic [7:0] exp, input int lo, input int hi);
    int n;
    n = 0;
    #1;
    while ((sel ? toe : out_run) !== exp && n <= hi) begin
      @(negedge comp_clk_i);
      #1;
      n++;
    end
    cmp({7'h0, n >= lo && n <= hi}, 8'h01);
    if (n > hi) summarize();
  endtask
  // ************************************
  // Block transfers
  // ************************************
  task automatic wr_blk(input logic [7:0] idx, input logic [7:0] d[$]);
    logic [7:0] rx;
    logic a, acc;
    acc = 1'b0;
    host_i.start();
    host_i.byte_xfer(`ADDR_WR, 1'b1, rx, a);
    acc |= a;
    host_i.byte_xfer(idx, 1'b1, rx, a);
    acc |= a;
    host_i.byte_xfer(8'(d.size()), 1'b1, rx, a);
    acc |= a;
    foreach (d[i]) begin
      host_i.byte_xfer(d[i], 1'b1, rx, a);
      acc |= a;
      if ((idx + i) inside {0, 1, 2, 3, 6}) regs[idx + i] = d[i];
    end
    host_i.stop();
    cmp({7'h0, acc}, 8'h00);
  endtask
  task automatic rd_blk(input logic [7:0] idx, input int n);
    logic [7:0] rx;
    logic a, acc;
    host_i.start();
    host_i.byte_xfer(`ADDR_WR, 1'b1, rx, a);
    acc = a;
    host_i.byte_xfer(idx, 1'b1, rx, a);
    acc |= a;
    host_i.start();
    host_i.byte_xfer(`ADDR_RD, 1'b1, rx, a);
    cmp({7'h0, acc | a}, 8'h00);
    host_i.byte_xfer(8'hff, 1'b0, rx, a);
    cmp(rx, regs[6]);
    for (int i = 0; i < n; i++) begin
      host_i.byte_xfer(8'hff, i == n - 1, rx, a);
      cmp(rx, exp_rd(idx + i));
    end
    host_i.stop();
  endtask
  // ************************************
  // Main sequence
  // ************************************
  initial begin
    logic [7:0] rx;
    logic a;
    errors = 0;
    total_checks = 0;
    reset_n_i = 1'b0;
    power_down_n_i = 1'b1;
    output_halt_n_i = 1'b1;
    regs = '{`RST_MODE, `RST_EN, `RST_STP, `RST_SPARE, 8'h00, 8'h00, `RST_LEN, 8'h00};
    void'($urandom(40));
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (100) @(posedge clk_i);
    rd_blk(8'h00, 8);
    cmp({5'h0, bw, zero_delay_mode, div}, 8'h07);
    host_i.start();
    host_i.byte_xfer(8'ha0, 1'b1, rx, a);
    host_i.stop();
    cmp({7'h0, a}, 8'h01);
    m = 8'($urandom) & 8'h3f;
    wr_blk(8'h00, '{m, 8'hff, 8'h00});
    wr_blk(8'h04, '{8'h11, 8'h22, 8'h05});
    rd_blk(8'h00, 8);
    cmp({5'h0, bw, zero_delay_mode, div}, {5'h0, m[2:0]});
    for (int md = 0; md < 2; md++) begin
      msk = 8'($urandom) | 8'h01;
      wr_blk(8'h00, '{{1'b0, md[0], 6'h07}, 8'hff, msk});
      @(posedge comp_clk_i);
      @(posedge clk_i);
      output_halt_n_i <= 1'b0;
      @(posedge comp_clk_i);
      @(posedge clk_i);
      output_halt_n_i <= 1'b1;
      repeat (6) @(negedge comp_clk_i);
      chk_out(8'hff, 8'hff, 8'hff);
      @(posedge clk_i);
      output_halt_n_i <= 1'b0;
      repeat (8) @(negedge comp_clk_i);
      chk_out(~msk, md ? ~msk : 8'hff, ~msk);
      @(posedge clk_i);
      output_halt_n_i <= 1'b1;
      // Input sync adds up to two periods to the window
      if (md == 1) wait_eq(1'b1, 8'hff, 1, 6);
      wait_eq(1'b0, 8'hff, md ? 0 : 2, 8);
      chk_out(8'hff, 8'hff, 8'hff);
    end
    for (int md = 0; md < 2; md++) begin
      en = 8'($urandom) | 8'h01;
      wr_blk(8'h00, '{{md[0], 7'h07}, en});
      @(posedge clk_i);
      power_down_n_i <= 1'b0;
      repeat (8) @(negedge comp_clk_i);
      chk_out(8'h00, md ? 8'h00 : en, 8'h00);
      cmp({7'h0, pll_run}, 8'h00);
      @(posedge clk_i);
      power_down_n_i <= 1'b1;
      if (md == 1) wait_eq(1'b1, en, 1, 8);
      k = 0;
      while ((out_run & en) !== en && k < LOCK + 200) begin
        @(posedge clk_i);
        k++;
      end
      cmp({pll_run, 6'h0, k < LOCK + 200}, 8'h81);
      if (k >= LOCK + 200) summarize();
      wr_blk(8'h01, '{8'hff});
    end
    summarize();
  end
endmodule

/* test/smbus_host_model.sv */
`timescale 1ns/1ps
module smbus_host_model (
  input wire logic clk_i,
  input wire logic dev_pull_i,
  output logic scl_o,
  output logic sda_o
);
  logic scl_reg;
  logic sda_reg;
  // Pull-up wire: low while either side pulls
  assign scl_o = scl_reg;
  assign sda_o = sda_reg & ~dev_pull_i;
  initial begin
    scl_reg = 1'b1;
    sda_reg = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // ************************************
  // Bus conditions, start doubles as repeated start
  // ************************************
  task automatic start();
    sda_reg <= 1'b1;
    hold(6);
    scl_reg <= 1'b1;
    hold(6);
    sda_reg <= 1'b0;
    hold(6);
    scl_reg <= 1'b0;
    hold(6);
  endtask
  task automatic stop();
    sda_reg <= 1'b0;
    hold(6);
    scl_reg <= 1'b1;
    hold(6);
    sda_reg <= 1'b1;
    hold(6);
  endtask
  // Data changes only while the clock is low
  task automatic bit_xfer(input logic b, output logic s);
    sda_reg <= b;
    hold(6);
    scl_reg <= 1'b1;
    hold(4);
    s = sda_o;
    hold(4);
    scl_reg <= 1'b0;
    hold(2);
  endtask
  // MSB first, then the acknowledge slot
  task automatic byte_xfer(input logic [7:0] tx, input logic ack_in,
                           output logic [7:0] rx, output logic ack_out);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(tx[i], s);
      rx[i] = s;
    end
    bit_xfer(ack_in, ack_out);
  endtask
endmodule
